// ---- hw/psp_port_cfg.sv ----
// Port S pin configuration: direction, pull, polarity and wired-or registers,
// peripheral direction overrides and the port data and input reads.
// Assumes synchronous register strobes and peripheral enables on clk_sys.
`timescale 1ns/10ps
module psp_port_cfg
    import psp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [PSP_AW-1:0] reg_addr,
    input wire logic [PSP_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [PSP_DW-1:0] reg_rdata,
    input wire logic [PSP_PINS-1:0] pad_in,
    output logic [PSP_PINS-1:0] pad_out,
    output logic [PSP_PINS-1:0] pad_oe_n,
    output logic [PSP_PINS-1:0] pull_up_en,
    output logic [PSP_PINS-1:0] pull_dn_en,
    input wire logic spi_en,
    input wire logic [3:0] spi_dir,
    input wire logic [3:0] spi_out,
    input wire logic bus_clock_output_en,
    input wire logic bus_clock_output_val,
    input wire logic second_async_serial_route_en,
    input wire logic second_async_serial_txd,
    input wire logic pwm_route_en,
    input wire logic [1:0] pwm_route_val,
    input wire logic async_serial_en,
    input wire logic [1:0] async_serial_dir,
    input wire logic [1:0] async_serial_out,
    input wire logic lin_direct_en,
    input wire logic lin_direct_drive_bit
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Address match for a strobe
    function automatic logic reg_hit(input logic strobe, input logic [PSP_AW-1:0] addr,
                                     input logic [PSP_AW-1:0] off);
        reg_hit = strobe && (addr == off);
    endfunction

    // Stored configuration and data
    logic [PSP_PINS-1:0] port_output_data_r;
    logic [PSP_PINS-1:0] pin_direction_r;
    logic [PSP_PINS-1:0] pull_enable_r;
    logic [PSP_PINS-1:0] pull_polarity_r;
    logic [PSP_PINS-1:0] open_drain_select_r;
    logic [PSP_PINS-1:0] pin_meta_r;
    logic [PSP_PINS-1:0] pin_sync_r;
    logic [PSP_DW-1:0] reg_rdata_r;

    // Write decodes
    logic wr_data;
    logic wr_dir;
    logic wr_pe;
    logic wr_pps;
    logic wr_od;
    logic [PSP_PINS-1:0] wr_pins;

    assign wr_data = reg_hit(reg_wr, reg_addr, PSP_OFF_DATA);
    assign wr_dir = reg_hit(reg_wr, reg_addr, PSP_OFF_DIR);
    assign wr_pe = reg_hit(reg_wr, reg_addr, PSP_OFF_PULL_EN);
    assign wr_pps = reg_hit(reg_wr, reg_addr, PSP_OFF_PULL_POL);
    assign wr_od = reg_hit(reg_wr, reg_addr, PSP_OFF_OPEN_DRAIN);
    // Only the six pin bits are kept; bits 7 and 6 are dropped
    assign wr_pins = reg_wdata[PSP_PIN_MSB:PSP_PIN_LSB];

    // Register file, written whenever the strobe hits
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            port_output_data_r <= PSP_RST_DATA;
            pin_direction_r <= PSP_RST_DIR;
            pull_enable_r <= PSP_RST_PULL_EN;
            pull_polarity_r <= PSP_RST_PULL_POL;
            open_drain_select_r <= PSP_RST_OPEN_DRAIN;
        end
        else
        begin
            if (wr_data)
                port_output_data_r <= wr_pins;
            if (wr_dir)
                pin_direction_r <= wr_pins;
            if (wr_pe)
                pull_enable_r <= wr_pins;
            if (wr_pps)
                pull_polarity_r <= wr_pins;
            if (wr_od)
                open_drain_select_r <= wr_pins;
        end
    end

    // Two-stage pin synchroniser
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pin_meta_r <= PSP_RST_DATA;
            pin_sync_r <= PSP_RST_DATA;
        end
        else
        begin
            pin_meta_r <= pad_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Effective direction and value per pin, peripherals first
    logic [PSP_PINS-1:0] dir_eff;
    logic [PSP_PINS-1:0] val_eff;
    logic pin3_forced_out;

    // Pins 5 and 4: serial peripheral interface or the direction bit
    assign dir_eff[5:4] = spi_en ? spi_dir[3:2] : pin_direction_r[5:4];
    assign val_eff[5:4] = spi_en ? spi_out[3:2] : port_output_data_r[5:4];

    // Pin 3: clock output, then SPI, then routed serial, then routed PWM
    assign pin3_forced_out = second_async_serial_route_en | pwm_route_en;
    assign dir_eff[3] = bus_clock_output_en ? 1'b1 :
                        spi_en ? spi_dir[1] :
                        pin3_forced_out ? 1'b1 :
                        pin_direction_r[3];
    assign val_eff[3] = bus_clock_output_en ? bus_clock_output_val :
                        spi_en ? spi_out[1] :
                        second_async_serial_route_en ? second_async_serial_txd :
                        pwm_route_en ? pwm_route_val[1] :
                        port_output_data_r[3];

    // Pin 2: SPI, then routed serial receive (input), then routed PWM
    assign dir_eff[2] = spi_en ? spi_dir[0] :
                        second_async_serial_route_en ? 1'b0 :
                        pwm_route_en ? 1'b1 :
                        pin_direction_r[2];
    assign val_eff[2] = spi_en ? spi_out[0] :
                        pwm_route_en ? pwm_route_val[0] :
                        port_output_data_r[2];

    // Pin 1: async serial interface, then LIN direct drive
    assign dir_eff[1] = async_serial_en ? async_serial_dir[1] :
                        lin_direct_en ? 1'b1 :
                        pin_direction_r[1];
    assign val_eff[1] = async_serial_en ? async_serial_out[1] :
                        lin_direct_en ? lin_direct_drive_bit :
                        port_output_data_r[1];

    // Pin 0: async serial interface or the direction bit
    assign dir_eff[0] = async_serial_en ? async_serial_dir[0] : pin_direction_r[0];
    assign val_eff[0] = async_serial_en ? async_serial_out[0] : port_output_data_r[0];

    // Settings handed to the pad stage
    psp_pin_if pin_bus ();

    assign pin_bus.dir_eff = dir_eff;
    assign pin_bus.val_eff = val_eff;
    assign pin_bus.open_drain = open_drain_select_r;
    assign pin_bus.pull_en = pull_enable_r;
    assign pin_bus.pull_pol = pull_polarity_r;

    psp_pin_ctl u_pin_ctl (
        .clk_sys(clk_sys),
        .rst(rst),
        .pins(pin_bus.ctl),
        .pad_out(pad_out),
        .pad_oe_n(pad_oe_n),
        .pull_up_en(pull_up_en),
        .pull_dn_en(pull_dn_en)
    );

    // Read selection
    logic [PSP_PINS-1:0] data_view;
    logic [PSP_PINS-1:0] rd_pins;
    logic rd_mapped;

    // Data read mixes stored output bits and synced pin levels by direction
    assign data_view = (pin_direction_r & port_output_data_r) |
                       (~pin_direction_r & pin_sync_r);
    assign rd_pins = (reg_addr == PSP_OFF_DATA) ? data_view :
                     (reg_addr == PSP_OFF_INPUT) ? pin_sync_r :
                     (reg_addr == PSP_OFF_DIR) ? pin_direction_r :
                     (reg_addr == PSP_OFF_PULL_EN) ? pull_enable_r :
                     (reg_addr == PSP_OFF_PULL_POL) ? pull_polarity_r :
                     (reg_addr == PSP_OFF_OPEN_DRAIN) ? open_drain_select_r :
                     PSP_RST_DATA;
    assign rd_mapped = reg_addr <= PSP_OFF_OPEN_DRAIN;

    // Read data stands for one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            reg_rdata_r <= PSP_RDATA_IDLE;
        else if (reg_rd && rd_mapped)
            reg_rdata_r <= {PSP_UNUSED_BITS, rd_pins};
        else
            reg_rdata_r <= PSP_RDATA_IDLE;
    end

    assign reg_rdata = reg_rdata_r;

    // Without overrides pin 4 follows its direction bit
    gpio_dir_a: assert property (!spi_en |-> dir_eff[4] == pin_direction_r[4])
        else $error("pin 4 direction ignores its bit");

    // SPI sets the direction of pins 5 and 4
    spi_force_a: assert property (spi_en |-> dir_eff[5:4] == spi_dir[3:2])
        else $error("SPI direction not applied");

    // An override leaves the stored direction untouched
    dir_hold_a: assert property ((spi_en || async_serial_en) && !wr_dir |=>
        $stable(pin_direction_r))
        else $error("direction bit changed under override");

    // Any pin 3 output function wins over an input direction bit
    pin3_out_a: assert property (bus_clock_output_en ||
        (!spi_en && (second_async_serial_route_en || pwm_route_en)) |-> dir_eff[3])
        else $error("pin 3 not forced to output");

    // Routed serial receive makes pin 2 an input
    pin2_in_a: assert property (!spi_en && second_async_serial_route_en |-> !dir_eff[2])
        else $error("pin 2 not forced to input");

    // Routed PWM alone makes pin 2 an output
    pin2_out_a: assert property (!spi_en && !second_async_serial_route_en && pwm_route_en
        |-> dir_eff[2])
        else $error("pin 2 not forced to output");

    // Async serial sets pins 1 and 0
    asi_force_a: assert property (async_serial_en |-> dir_eff[1:0] == async_serial_dir)
        else $error("async serial direction not applied");

    // LIN direct drive makes pin 1 an output and drives its bit
    lin_drive_a: assert property (!async_serial_en && lin_direct_en |->
        dir_eff[1] && val_eff[1] == lin_direct_drive_bit)
        else $error("LIN drive not on pin 1");

    // A direction write reaches the register and reads back
    cfg_write_a: assert property (wr_dir ##1 (reg_rd && reg_addr == PSP_OFF_DIR && !reg_wr)
        |=> reg_rdata[5:0] == pin_direction_r && pin_direction_r == $past(reg_wdata[5:0], 2))
        else $error("direction write lost");

    // Data read picks stored or synced bit by direction
    data_read_a: assert property (reg_rd && reg_addr == PSP_OFF_DATA |=>
        reg_rdata[5:0] == (($past(pin_direction_r) & $past(port_output_data_r)) |
                           (~$past(pin_direction_r) & $past(pin_sync_r))))
        else $error("port data read wrong");

    // Upper bits always read zero
    top_bits_a: assert property (reg_rd |=> reg_rdata[7:6] == 2'h0)
        else $error("unimplemented bits not zero");

    // Read data drops back to idle when no read was asked for
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == PSP_RDATA_IDLE)
        else $error("read data not idle");

    // Unmapped indices read as zero
    unmapped_read_a: assert property (reg_rd && reg_addr > PSP_OFF_OPEN_DRAIN |=>
        reg_rdata == PSP_RDATA_IDLE)
        else $error("unmapped read not zero");

    // Input read returns the synchronised pin levels
    input_read_a: assert property (reg_rd && reg_addr == PSP_OFF_INPUT |=>
        reg_rdata[5:0] == $past(pin_sync_r))
        else $error("input read wrong");

    // A direction write stores the low six bits
    dir_write_a: assert property (wr_dir |=> pin_direction_r == $past(reg_wdata[5:0]))
        else $error("direction write not stored");

    // A pull-enable write stores the low six bits
    pull_write_a: assert property (wr_pe |=> pull_enable_r == $past(reg_wdata[5:0]))
        else $error("pull enable write not stored");

    // Without async serial pin 0 follows its direction bit
    pin0_gpio_a: assert property (!async_serial_en |-> dir_eff[0] == pin_direction_r[0])
        else $error("pin 0 direction ignores its bit");

    // Clock output drives pin 3 with its own value
    clk_out_a: assert property (bus_clock_output_en |->
        dir_eff[3] && val_eff[3] == bus_clock_output_val)
        else $error("clock output not on pin 3");

    // Pin 1 falls back to its direction bit with no override
    pin1_gpio_a: assert property (!async_serial_en && !lin_direct_en |->
        dir_eff[1] == pin_direction_r[1])
        else $error("pin 1 direction ignores its bit");

    // SPI wins over routed functions on pins 3 and 2
    spi_priority_a: assert property (spi_en && !bus_clock_output_en |->
        dir_eff[3:2] == spi_dir[1:0] && val_eff[2] == spi_out[0])
        else $error("SPI not taking pins 3 and 2");
endmodule

// ---- hw/psp_pkg.sv ----
// Constants for the port S pin configuration block.
// Assumes an 8-bit register port with a small local address space.
package psp_pkg;
    // Register port widths
    localparam int PSP_AW = 3;
    localparam int PSP_DW = 8;
    localparam int PSP_PINS = 6;
    // Register offsets
    localparam logic [PSP_AW-1:0] PSP_OFF_DATA = 3'h0;
    localparam logic [PSP_AW-1:0] PSP_OFF_INPUT = 3'h1;
    localparam logic [PSP_AW-1:0] PSP_OFF_DIR = 3'h2;
    localparam logic [PSP_AW-1:0] PSP_OFF_PULL_EN = 3'h3;
    localparam logic [PSP_AW-1:0] PSP_OFF_PULL_POL = 3'h4;
    localparam logic [PSP_AW-1:0] PSP_OFF_OPEN_DRAIN = 3'h5;
    // Field layout: pins sit in the low bits, the top bits are unimplemented
    localparam int PSP_PIN_LSB = 0;
    localparam int PSP_PIN_MSB = 5;
    localparam logic [1:0] PSP_UNUSED_BITS = 2'h0;
    // Reset values
    localparam logic [PSP_PINS-1:0] PSP_RST_DATA = 6'h00;
    localparam logic [PSP_PINS-1:0] PSP_RST_DIR = 6'h00;
    localparam logic [PSP_PINS-1:0] PSP_RST_PULL_EN = 6'h00;
    localparam logic [PSP_PINS-1:0] PSP_RST_PULL_POL = 6'h00;
    localparam logic [PSP_PINS-1:0] PSP_RST_OPEN_DRAIN = 6'h00;
    localparam logic [PSP_DW-1:0] PSP_RDATA_IDLE = 8'h00;
endpackage

// ---- hw/psp_pin_if.sv ----
// Carrier for per-pin settings from the register side to the pad drivers.
// Assumes both ends run on clk_sys.
`timescale 1ns/10ps
interface psp_pin_if;
    import psp_pkg::*;
    logic [PSP_PINS-1:0] dir_eff;
    logic [PSP_PINS-1:0] val_eff;
    logic [PSP_PINS-1:0] open_drain;
    logic [PSP_PINS-1:0] pull_en;
    logic [PSP_PINS-1:0] pull_pol;
    modport cfg (output dir_eff, val_eff, open_drain, pull_en, pull_pol);
    modport ctl (input dir_eff, val_eff, open_drain, pull_en, pull_pol);
endinterface

// ---- hw/psp_pin_ctl.sv ----
// Pad driver stage: output enable, drive value and pull selection per pin.
// Assumes settings arrive through psp_pin_if and pads resolve the enables.
`timescale 1ns/10ps
module psp_pin_ctl
    import psp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    psp_pin_if.ctl pins,
    output logic [PSP_PINS-1:0] pad_out,
    output logic [PSP_PINS-1:0] pad_oe_n,
    output logic [PSP_PINS-1:0] pull_up_en,
    output logic [PSP_PINS-1:0] pull_dn_en
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    genvar i;
    generate
        for (i = 0; i < PSP_PINS; i++)
        begin : g_pin
            logic drive;
            logic level;
            logic pull_on;
            // Open-drain drives only a low, push-pull drives both levels
            assign drive = pins.dir_eff[i] & ~(pins.open_drain[i] & pins.val_eff[i]);
            assign level = pins.open_drain[i] ? 1'b0 : pins.val_eff[i];
            // Pull acts on inputs, and on outputs only in wired-or mode
            assign pull_on = pins.pull_en[i] & (~pins.dir_eff[i] | pins.open_drain[i]);

            // Registered pad controls
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                begin
                    pad_out[i] <= 1'b0;
                    pad_oe_n[i] <= 1'b1;
                    pull_up_en[i] <= 1'b0;
                    pull_dn_en[i] <= 1'b0;
                end
                else
                begin
                    pad_out[i] <= level;
                    pad_oe_n[i] <= ~drive;
                    pull_up_en[i] <= pull_on & ~pins.pull_pol[i];
                    pull_dn_en[i] <= pull_on & pins.pull_pol[i];
                end
            end

            // Open-drain high leaves the pin undriven, low drives it
            od_release_a: assert property (pins.dir_eff[i] && pins.open_drain[i] |=>
                pad_oe_n[i] == $past(pins.val_eff[i]) && !pad_out[i])
                else $error("open-drain pin drive wrong");
            // An input pin is never driven, whatever wired-or says
            input_float_a: assert property (!pins.dir_eff[i] |=> pad_oe_n[i])
                else $error("input pin driven");
            // Push-pull output keeps its pull off
            pushpull_pull_a: assert property (pins.dir_eff[i] && !pins.open_drain[i] |=>
                !pull_up_en[i] && !pull_dn_en[i])
                else $error("pull active on push-pull output");
            // Enabled pull on an input follows the polarity bit
            pull_pol_a: assert property (!pins.dir_eff[i] && pins.pull_en[i] |=>
                pull_dn_en[i] == $past(pins.pull_pol[i]) && pull_up_en[i] != pull_dn_en[i])
                else $error("pull polarity wrong on input");
        end
    endgenerate
endmodule

// ---- bench/psp_pad_model.sv ----
// Board-side model of the six port S pins: pad drivers, pull devices, float.
// Assumes pad outputs from the configuration block and one bench clock.
`timescale 1ns/10ps
module psp_pad_model
    import psp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [PSP_PINS-1:0] pad_out,
    input wire logic [PSP_PINS-1:0] pad_oe_n,
    input wire logic [PSP_PINS-1:0] pull_up_en,
    input wire logic [PSP_PINS-1:0] pull_dn_en,
    output logic [PSP_PINS-1:0] pad_in
);
    logic [PSP_PINS-1:0] float_r;

    // Undriven, unpulled pins wander so a stale level is never read back
    always @(posedge clk_sys)
    begin
        float_r <= ~float_r;
    end

    initial float_r = 6'h15;

    // Driver wins, then pullup, then pulldown, else floating pattern
    always_comb
    begin
        for (int i = 0; i < PSP_PINS; i++)
        begin
            if (!pad_oe_n[i])
                pad_in[i] = pad_out[i];
            else if (pull_up_en[i])
                pad_in[i] = 1'b1;
            else if (pull_dn_en[i])
                pad_in[i] = 1'b0;
            else
                pad_in[i] = float_r[i];
        end
    end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the port S configuration block.
// Assumes the block's register port and the pad model on the pin side.
`timescale 1ns/10ps
module tb_top
    import psp_pkg::*;
;
    logic clk_sys, rst, reg_wr, reg_rd;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, q;
    logic [5:0] pad_in, pad_out, pad_oe_n, pull_up_en, pull_dn_en;
    logic spi_en, bus_clock_output_en, bus_clock_output_val, second_async_serial_route_en;
    logic second_async_serial_txd, pwm_route_en, async_serial_en, lin_direct_en;
    logic lin_direct_drive_bit;
    logic [3:0] spi_dir, spi_out;
    logic [1:0] pwm_route_val, async_serial_dir, async_serial_out;
    logic [22:0] ovr;
    logic [5:0] dir_s, dat_s, pe_s, pol_s, od_s, e_oe, e_val, e_pu, e_pd, e_lvl, e_msk;
    int n_fail = 0;
    int cmp_count = 0;
    logic [29:0] cfgs [3] = '{{6'h00, 6'h3F, 6'h3F, 6'h15, 6'h00},
        {6'h3F, 6'h2A, 6'h3F, 6'h2A, 6'h3F}, {6'h0F, 6'h33, 6'h3C, 6'h30, 6'h28}};
    logic [22:0] rows [8] = '{23'b1_1010_0110_0_0_0_0_0_00_0_00_00_0_0,
        23'b1_0000_1111_1_1_0_0_0_00_0_00_00_0_0, 23'b0_0000_0000_0_0_1_1_1_11_0_00_00_0_0,
        23'b0_0000_0000_0_0_0_0_1_01_0_00_00_0_0, 23'b0_0000_0000_0_0_0_0_0_00_1_01_11_1_0,
        23'b0_0000_0000_0_0_0_0_0_00_0_00_00_1_1, 23'b0_0000_0000_1_0_1_0_0_00_1_11_10_0_0,
        23'h000000};

    // Peripheral override inputs unpacked from one vector
    assign {spi_en, spi_dir, spi_out, bus_clock_output_en, bus_clock_output_val,
        second_async_serial_route_en, second_async_serial_txd, pwm_route_en, pwm_route_val,
        async_serial_en, async_serial_dir, async_serial_out, lin_direct_en,
        lin_direct_drive_bit} = ovr;

    psp_port_cfg psp_port_cfg_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en),
        .pull_dn_en(pull_dn_en), .spi_en(spi_en), .spi_dir(spi_dir), .spi_out(spi_out),
        .bus_clock_output_en(bus_clock_output_en), .bus_clock_output_val(bus_clock_output_val),
        .second_async_serial_route_en(second_async_serial_route_en),
        .second_async_serial_txd(second_async_serial_txd), .pwm_route_en(pwm_route_en),
        .pwm_route_val(pwm_route_val), .async_serial_en(async_serial_en),
        .async_serial_dir(async_serial_dir), .async_serial_out(async_serial_out),
        .lin_direct_en(lin_direct_en), .lin_direct_drive_bit(lin_direct_drive_bit));

    psp_pad_model psp_pad_model_inst (.clk_sys(clk_sys), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .pad_in(pad_in));

    // Clock at 4 ns
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Counts and verdict, the single end of the run
    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk_reg(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_pin(input logic [5:0] got, input logic [5:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t pins got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // One-cycle read strobe, data taken in the following cycle only
    task rd_chk(input logic [2:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk_reg(reg_rdata, exp);
    endtask

    // Expected pin state, lowest priority override applied first
    task calc;
        logic [5:0] d;
        logic [5:0] v;
        d = dir_s;
        v = dat_s;
        if (pwm_route_en) {d[3:2], v[3:2]} = {2'h3, pwm_route_val};
        if (second_async_serial_route_en) {d[3:2], v[3]} = {2'h2, second_async_serial_txd};
        if (spi_en) {d[5:2], v[5:2]} = {spi_dir, spi_out};
        if (bus_clock_output_en) {d[3], v[3]} = {1'b1, bus_clock_output_val};
        if (lin_direct_en) {d[1], v[1]} = {1'b1, lin_direct_drive_bit};
        if (async_serial_en) {d[1:0], v[1:0]} = {async_serial_dir, async_serial_out};
        e_oe = ~d | (od_s & v);
        e_msk = d & ~od_s;
        e_val = v & e_msk;
        e_pu = pe_s & (~d | od_s) & ~pol_s;
        e_pd = pe_s & (~d | od_s) & pol_s;
        e_lvl = (~e_oe & e_val) | (e_oe & e_pu);
    endtask

    task chk_pads;
        repeat (2) @(posedge clk_sys);
        #1;
        calc;
        chk_pin(pad_oe_n, e_oe);
        chk_pin(pad_out & e_msk, e_val);
        chk_pin(pull_up_en, e_pu);
        chk_pin(pull_dn_en, e_pd);
    endtask

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        give_verdict;
    end

    // Main sequence
    initial
    begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, ovr} <= '0;
        rst <= 1'b1;
        dir_s = 6'h00;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk_pin(pad_oe_n, 6'h3F);
        chk_pin(pull_up_en | pull_dn_en, 6'h00);
        for (int a = 2; a < 8; a++)
            rd_chk(a[2:0], 8'h00);
        $display("test reset done");
        // Register access, top bits and unmapped place 6
        for (int a = 2; a < 6; a++)
        begin
            wr(a[2:0], 8'hFF);
            rd_chk(a[2:0], 8'h3F);
            wr(a[2:0], 8'h95);
            rd_chk(a[2:0], 8'h15);
            wr(a[2:0], 8'h00);
        end
        wr(3'h6, 8'hFF);
        rd_chk(3'h6, 8'h00);
        $display("test registers done");
        // Settings crossed with peripheral overrides
        for (int c = 0; c < 3; c++)
        begin
            {dir_s, dat_s, pe_s, pol_s, od_s} = cfgs[c];
            wr(3'h0, {2'h3, dat_s});
            wr(3'h2, {2'h3, dir_s});
            wr(3'h3, {2'h3, pe_s});
            wr(3'h4, {2'h3, pol_s});
            wr(3'h5, {2'h3, od_s});
            for (int r = 0; r < 8; r++)
            begin
                ovr <= rows[r];
                chk_pads;
            end
            rd_chk(3'h2, {2'h0, dir_s});
            repeat (3) @(posedge clk_sys);
            rd_chk(3'h0, {2'h0, (dir_s & dat_s) | (~dir_s & e_lvl)});
            rd_chk(3'h1, {2'h0, e_lvl});
            $display("test config %0d done", c);
        end
        give_verdict;
    end
endmodule
